// ==== hw/tsr_pkg.sv ====
// Purpose: constants and types for the serial temperature sensor block
// Assumes: core clock 250 MHz, serial clock supplied by the bus master
// Notes: registers are 16 bits, addressed by an 8-bit pointer
package tsr_pkg;

  localparam logic [7:0]  PTR_CAP    = 8'h00;
  localparam logic [7:0]  PTR_CFG    = 8'h01;
  localparam logic [7:0]  PTR_HIGH   = 8'h02;
  localparam logic [7:0]  PTR_LOW    = 8'h03;
  localparam logic [7:0]  PTR_CRIT   = 8'h04;
  localparam logic [7:0]  PTR_TEMP   = 8'h05;
  localparam logic [7:0]  PTR_MAKER  = 8'h06;
  localparam logic [7:0]  PTR_PART   = 8'h07;
  localparam logic [7:0]  PTR_RESET  = 8'h00;

  localparam logic [15:0] CAP_RESET  = 16'h007F;
  localparam logic [15:0] RW_RESET   = 16'h0000;
  localparam logic [15:0] LIMIT_MASK = 16'h1FFC;
  localparam logic [12:0] TEMP_RESET = 13'h0000;
  localparam logic [3:0]  PREAMBLE   = 4'h3;

  localparam int CFG_MODE   = 0;
  localparam int CFG_POL    = 1;
  localparam int CFG_CRIT   = 2;
  localparam int CFG_ENA    = 3;
  localparam int CFG_STS    = 4;
  localparam int CFG_CLEAR  = 5;
  localparam int CFG_LOCK_A = 6;
  localparam int CFG_LOCK_C = 7;
  localparam int CFG_SHDN   = 8;
  localparam int CFG_HYS_LO = 9;
  localparam int CFG_HYS_HI = 10;

  localparam logic [3:0] BIT_FIRST = 4'h1;
  localparam logic [3:0] BIT_ACK   = 4'h8;
  localparam logic [1:0] WB_HI     = 2'h0;
  localparam logic [1:0] WB_LO     = 2'h1;
  localparam logic [1:0] WB_DONE   = 2'h2;

  localparam int CLK_KHZ     = 250000;
  localparam int CONV_MS     = 100;
  localparam int CONV_CYC    = CONV_MS * CLK_KHZ;
  localparam int TOUT_MIN_MS = 25;
  localparam int TOUT_MAX_MS = 35;
  localparam int TOUT_CYC    = TOUT_MIN_MS * CLK_KHZ;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEVADR,
    ST_REGADR,
    ST_WDATA,
    ST_RDATA
  } tsr_link_e;

  typedef struct packed {
    logic [7:0]  ptr;
    logic [15:0] data;
    logic        full;
  } tsr_wr_s;

  typedef struct packed {
    logic over_crit;
    logic above_high;
    logic below_low;
  } tsr_trip_s;

endpackage

// ==== hw/tsr_top.sv ====
// Purpose: two-wire slave and register file of a temperature sensor
// Assumes: scl clocks the link logic; clk runs the core at 250 MHz
// Notes: open-drain pins appear as output level plus output enable
`timescale 1ns/1ps
`default_nettype none
module tsr_top #(
  parameter int          CONV_CYC = tsr_pkg::CONV_CYC,
  parameter int          TOUT_CYC = tsr_pkg::TOUT_CYC,
  // Identity values are arbitrary
  parameter logic [15:0] MAKER_ID = 16'h5A5A,
  parameter logic [15:0] PART_REV = 16'h0101
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        scl,
  input  wire logic        sda_i,
  output var  logic        sda_o,
  output var  logic        sda_oe,
  input  wire logic        addr_select_0,
  input  wire logic        addr_select_1,
  input  wire logic        addr_select_2,
  input  wire logic [12:0] proportional_sensor_code,
  output var  logic        conv_start,
  output var  logic        alert_o,
  output var  logic        alert_oe
);

  ////////////////////////////////////////////////////////////////////
  // Declarations
  tsr_pkg::tsr_link_e state_q;
  tsr_pkg::tsr_wr_s   wr_q;
  tsr_pkg::tsr_trip_s trip;
  logic [3:0]         bitcnt_q;
  logic [7:0]         shreg_q;
  logic [7:0]         ptr_q;
  logic [1:0]         wbyte_q;
  logic               rd_lo_q;
  logic               rd_busy_q;
  logic               start_tgl_q;
  logic               stop_tgl_q;
  logic               start_seen_q;
  logic [2:0]         apin1_q;
  logic [2:0]         apin2_q;
  logic               sda_oe_q;
  logic               link_rst_n;
  logic               start_pend;
  logic               byte_done;
  logic               dev_match;
  logic [7:0]         rd_byte;
  logic [3:0]         sync1_q;
  logic [3:0]         sync2_q;
  logic [3:0]         prev_q;
  logic               start_ev;
  logic               stop_ev;
  logic               scl_fall;
  logic               busy_q;
  logic               abort_q;
  logic [31:0]        tout_cnt_q;
  logic [31:0]        conv_cnt_q;
  logic               conv_q;
  logic               commit;
  logic [15:0]        cfg_q;
  logic [15:0]        high_q;
  logic [15:0]        low_q;
  logic [15:0]        crit_q;
  logic [12:0]        temp_q;
  logic [15:0]        rd_word_q;
  logic [15:0]        rd_word_d;
  logic               lock;
  logic               shdn;
  logic               cond;
  logic               cond_prev_q;
  logic               int_q;
  logic               evt;
  logic               alert_oe_q;
  logic               pull_lvl_q;

  ////////////////////////////////////////////////////////////////////
  // Link reset: power-on or bus timeout
  assign link_rst_n = resetn & ~abort_q;

  ////////////////////////////////////////////////////////////////////
  // Start and stop detectors
  always_ff @(negedge sda_i or negedge link_rst_n)
  begin
    if (!link_rst_n)
      start_tgl_q <= 1'b0;
    else if (scl)
      start_tgl_q <= ~start_tgl_q;
  end

  always_ff @(posedge sda_i or negedge link_rst_n)
  begin
    if (!link_rst_n)
      stop_tgl_q <= 1'b0;
    else if (scl)
      stop_tgl_q <= ~stop_tgl_q;
  end

  ////////////////////////////////////////////////////////////////////
  // Address pin synchroniser on the link clock
  always_ff @(posedge scl or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      apin1_q <= 3'h0;
      apin2_q <= 3'h0;
    end
    else
    begin
      apin1_q <= {addr_select_2, addr_select_1, addr_select_0};
      apin2_q <= apin1_q;
    end
  end

  assign start_pend = start_tgl_q ^ start_seen_q;
  assign byte_done  = (bitcnt_q == tsr_pkg::BIT_ACK);
  assign dev_match  = (shreg_q[7:4] == tsr_pkg::PREAMBLE) &&
                      (shreg_q[3:1] == apin2_q);

  ////////////////////////////////////////////////////////////////////
  // Frame sequencer, samples on rising scl
  always_ff @(posedge scl or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      state_q      <= tsr_pkg::ST_IDLE;
      bitcnt_q     <= 4'h0;
      shreg_q      <= 8'h00;
      start_seen_q <= 1'b0;
    end
    else if (start_pend)
    begin
      start_seen_q <= start_tgl_q;
      state_q      <= tsr_pkg::ST_DEVADR;
      bitcnt_q     <= tsr_pkg::BIT_FIRST;
      shreg_q      <= {shreg_q[6:0], sda_i};
    end
    else if (state_q != tsr_pkg::ST_IDLE)
    begin
      if (!byte_done)
      begin
        shreg_q  <= {shreg_q[6:0], sda_i};
        bitcnt_q <= bitcnt_q + 4'h1;
      end
      else
      begin
        bitcnt_q <= 4'h0;
        case (state_q)
          tsr_pkg::ST_DEVADR:
          begin
            if (!dev_match)
              state_q <= tsr_pkg::ST_IDLE;
            else if (shreg_q[0])
              state_q <= tsr_pkg::ST_RDATA;
            else
              state_q <= tsr_pkg::ST_REGADR;
          end
          tsr_pkg::ST_REGADR:
            state_q <= tsr_pkg::ST_WDATA;
          tsr_pkg::ST_WDATA:
            state_q <= tsr_pkg::ST_WDATA;
          tsr_pkg::ST_RDATA:
          begin
            if (sda_i)
              state_q <= tsr_pkg::ST_IDLE;
          end
          default:
            state_q <= tsr_pkg::ST_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pointer and write capture
  always_ff @(posedge scl or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      ptr_q   <= tsr_pkg::PTR_RESET;
      wr_q    <= '0;
      wbyte_q <= tsr_pkg::WB_HI;
    end
    else if (start_pend)
    begin
      wr_q.full <= 1'b0;
      wbyte_q   <= tsr_pkg::WB_HI;
    end
    else if (byte_done && state_q == tsr_pkg::ST_REGADR)
    begin
      ptr_q    <= shreg_q;
      wr_q.ptr <= shreg_q;
    end
    else if (byte_done && state_q == tsr_pkg::ST_WDATA)
    begin
      if (wbyte_q == tsr_pkg::WB_HI)
      begin
        wr_q.data[15:8] <= shreg_q;
        wbyte_q         <= tsr_pkg::WB_LO;
      end
      else if (wbyte_q == tsr_pkg::WB_LO)
      begin
        wr_q.data[7:0] <= shreg_q;
        wr_q.full      <= 1'b1;
        wbyte_q        <= tsr_pkg::WB_DONE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read byte select and read-word hold request
  always_ff @(posedge scl or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      rd_lo_q   <= 1'b0;
      rd_busy_q <= 1'b0;
    end
    else if (start_pend)
    begin
      rd_lo_q   <= 1'b0;
      rd_busy_q <= 1'b0;
    end
    else if (byte_done && state_q == tsr_pkg::ST_DEVADR)
      rd_busy_q <= dev_match & shreg_q[0];
    else if (byte_done && state_q == tsr_pkg::ST_RDATA)
      rd_lo_q <= ~rd_lo_q;
  end

  assign rd_byte = rd_lo_q ? rd_word_q[7:0] : rd_word_q[15:8];

  ////////////////////////////////////////////////////////////////////
  // Data line driver, changes on falling scl
  always_ff @(negedge scl or negedge link_rst_n)
  begin
    if (!link_rst_n)
      sda_oe_q <= 1'b0;
    else
    begin
      case (state_q)
        tsr_pkg::ST_DEVADR:
          sda_oe_q <= byte_done & dev_match;
        tsr_pkg::ST_REGADR:
          sda_oe_q <= byte_done;
        tsr_pkg::ST_WDATA:
          sda_oe_q <= byte_done;
        tsr_pkg::ST_RDATA:
          sda_oe_q <= ~byte_done & ~rd_byte[~bitcnt_q[2:0]];
        default:
          sda_oe_q <= 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Core-side synchronisers: scl, start, stop, read hold
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      prev_q  <= 4'h0;
    end
    else
    begin
      sync1_q <= {rd_busy_q, stop_tgl_q, start_tgl_q, scl};
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  assign start_ev = (sync2_q[1] ^ prev_q[1]) & ~abort_q;
  assign stop_ev  = sync2_q[2] ^ prev_q[2];
  assign scl_fall = prev_q[0] & ~sync2_q[0];
  assign commit   = stop_ev & wr_q.full;

  ////////////////////////////////////////////////////////////////////
  // Bus timeout
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      busy_q     <= 1'b0;
      abort_q    <= 1'b0;
      tout_cnt_q <= 32'h0;
    end
    else
    begin
      if (abort_q && sync2_q[0])
        abort_q <= 1'b0;
      if (start_ev)
        busy_q <= 1'b1;
      else if (stop_ev || abort_q)
        busy_q <= 1'b0;
      if (!busy_q || scl_fall || sync2_q[0])
        tout_cnt_q <= 32'h0;
      else if (tout_cnt_q == 32'(TOUT_CYC - 1))
      begin
        abort_q    <= 1'b1;
        busy_q     <= 1'b0;
        tout_cnt_q <= 32'h0;
      end
      else
        tout_cnt_q <= tout_cnt_q + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Conversion schedule
  assign shdn = cfg_q[tsr_pkg::CFG_SHDN];

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      conv_cnt_q <= 32'h0;
      conv_q     <= 1'b0;
      temp_q     <= tsr_pkg::TEMP_RESET;
    end
    else
    begin
      conv_q <= 1'b0;
      if (conv_cnt_q == 32'(CONV_CYC - 1))
      begin
        conv_cnt_q <= 32'h0;
        if (!shdn)
        begin
          conv_q <= 1'b1;
          temp_q <= proportional_sensor_code;
        end
      end
      else
        conv_cnt_q <= conv_cnt_q + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Writable registers, committed at stop
  assign lock = cfg_q[tsr_pkg::CFG_LOCK_A] | cfg_q[tsr_pkg::CFG_LOCK_C];

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cfg_q  <= tsr_pkg::RW_RESET;
      high_q <= tsr_pkg::RW_RESET;
      low_q  <= tsr_pkg::RW_RESET;
      crit_q <= tsr_pkg::RW_RESET;
    end
    else if (commit)
    begin
      case (wr_q.ptr)
        tsr_pkg::PTR_CFG:
        begin
          if (!lock)
          begin
            cfg_q[tsr_pkg::CFG_MODE] <= wr_q.data[tsr_pkg::CFG_MODE];
            cfg_q[tsr_pkg::CFG_POL]  <= wr_q.data[tsr_pkg::CFG_POL];
            cfg_q[tsr_pkg::CFG_ENA]  <= wr_q.data[tsr_pkg::CFG_ENA];
            cfg_q[tsr_pkg::CFG_HYS_HI:tsr_pkg::CFG_HYS_LO] <=
              wr_q.data[tsr_pkg::CFG_HYS_HI:tsr_pkg::CFG_HYS_LO];
          end
          cfg_q[tsr_pkg::CFG_CRIT] <= wr_q.data[tsr_pkg::CFG_CRIT] &
            (~cfg_q[tsr_pkg::CFG_LOCK_A] | cfg_q[tsr_pkg::CFG_CRIT]);
          cfg_q[tsr_pkg::CFG_SHDN] <= wr_q.data[tsr_pkg::CFG_SHDN] &
            (~lock | cfg_q[tsr_pkg::CFG_SHDN]);
          cfg_q[tsr_pkg::CFG_LOCK_A] <= cfg_q[tsr_pkg::CFG_LOCK_A] |
            wr_q.data[tsr_pkg::CFG_LOCK_A];
          cfg_q[tsr_pkg::CFG_LOCK_C] <= cfg_q[tsr_pkg::CFG_LOCK_C] |
            wr_q.data[tsr_pkg::CFG_LOCK_C];
        end
        tsr_pkg::PTR_HIGH:
          if (!cfg_q[tsr_pkg::CFG_LOCK_A])
            high_q <= wr_q.data & tsr_pkg::LIMIT_MASK;
        tsr_pkg::PTR_LOW:
          if (!cfg_q[tsr_pkg::CFG_LOCK_A])
            low_q <= wr_q.data & tsr_pkg::LIMIT_MASK;
        tsr_pkg::PTR_CRIT:
          if (!cfg_q[tsr_pkg::CFG_LOCK_C])
            crit_q <= wr_q.data & tsr_pkg::LIMIT_MASK;
        default:
          cfg_q <= cfg_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Limit comparison and event
  assign trip.over_crit  = $signed(temp_q) >= $signed(crit_q[12:0]);
  assign trip.above_high = $signed(temp_q) > $signed(high_q[12:0]);
  assign trip.below_low  = $signed(temp_q) < $signed(low_q[12:0]);

  assign cond = cfg_q[tsr_pkg::CFG_CRIT] ? trip.over_crit :
                (trip.over_crit | trip.above_high | trip.below_low);

  assign evt = cfg_q[tsr_pkg::CFG_ENA] & ~shdn &
               (cfg_q[tsr_pkg::CFG_MODE] ? (int_q | trip.over_crit) : cond);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cond_prev_q <= 1'b0;
      int_q       <= 1'b0;
    end
    else
    begin
      cond_prev_q <= cond;
      if (cond && !cond_prev_q && !shdn)
        int_q <= 1'b1;
      else if (commit && wr_q.ptr == tsr_pkg::PTR_CFG &&
               wr_q.data[tsr_pkg::CFG_CLEAR] && !trip.over_crit)
        int_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Alert pin and fixed low levels
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      alert_oe_q <= 1'b0;
      pull_lvl_q <= 1'b0;
    end
    else
    begin
      pull_lvl_q <= 1'b0;
      alert_oe_q <= cfg_q[tsr_pkg::CFG_ENA] ?
                    (evt ^ cfg_q[tsr_pkg::CFG_POL]) : cfg_q[tsr_pkg::CFG_POL];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read word, held while a read is in progress
  always_comb
  begin
    rd_word_d = 16'h0000;
    case (ptr_q)
      tsr_pkg::PTR_CAP:   rd_word_d = tsr_pkg::CAP_RESET;
      tsr_pkg::PTR_CFG:
      begin
        rd_word_d = cfg_q;
        rd_word_d[tsr_pkg::CFG_STS] = evt;
      end
      tsr_pkg::PTR_HIGH:  rd_word_d = high_q;
      tsr_pkg::PTR_LOW:   rd_word_d = low_q;
      tsr_pkg::PTR_CRIT:  rd_word_d = crit_q;
      tsr_pkg::PTR_TEMP:  rd_word_d = {trip, temp_q};
      tsr_pkg::PTR_MAKER: rd_word_d = MAKER_ID;
      tsr_pkg::PTR_PART:  rd_word_d = PART_REV;
      default:            rd_word_d = 16'h0000;
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rd_word_q <= tsr_pkg::CAP_RESET;
    else if (!sync2_q[3])
      rd_word_q <= rd_word_d;
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs
  assign sda_o      = pull_lvl_q;
  assign sda_oe     = sda_oe_q;
  assign alert_o    = pull_lvl_q;
  assign alert_oe   = alert_oe_q;
  assign conv_start = conv_q;

endmodule
`default_nettype wire

// ==== verification/tsr_chk.sv ====
// Purpose: concurrent checks on the sensor block pins
// Assumes: bound to the top module, core clock domain only
// Notes: counts shortened by parameters passed through the bind
`timescale 1ns/1ps
`default_nettype none
module tsr_chk #(
  parameter int CONV_CYC = 200,
  parameter int TOUT_CYC = 2000
) (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        scl,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe,
  input wire logic        addr_select_0,
  input wire logic        addr_select_1,
  input wire logic        addr_select_2,
  input wire logic [12:0] proportional_sensor_code,
  input wire logic        conv_start,
  input wire logic        alert_o,
  input wire logic        alert_oe
);
  int   gap_q;
  int   low_q;
  logic seen_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  ////////////////////////////////////////////////////////////////////////////////
  // Cycles since the last conversion tick and since the serial clock fell
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      gap_q  <= 0;
      seen_q <= 1'b0;
    end
    else if (conv_start)
    begin
      gap_q  <= 0;
      seen_q <= 1'b1;
    end
    else if (gap_q < CONV_CYC + 8)
      gap_q <= gap_q + 1;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      low_q <= 0;
    else if (scl)
      low_q <= 0;
    else if (low_q < TOUT_CYC + 16)
      low_q <= low_q + 1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  sequence s_stop;
    scl && $rose(sda_i);
  endsequence

  a_sda_o_low: assert property (sda_o == 1'b0)
    else $error("data output level not low");
  a_alert_o_low: assert property (alert_o == 1'b0)
    else $error("alert output level not low");
  a_oe_on_fall: assert property ($changed(sda_oe) |-> !scl)
    else $error("data pull changed with clock high");
  a_conv_single: assert property (conv_start |=> !conv_start)
    else $error("conversion pulse longer than one cycle");
  a_conv_period: assert property (conv_start && seen_q |-> gap_q == CONV_CYC - 1)
    else $error("conversion period wrong");
  a_conv_bound: assert property (gap_q <= CONV_CYC)
    else $error("conversion tick missing");
  a_tout_release: assert property (low_q > TOUT_CYC + 8 |-> !sda_oe)
    else $error("data held after clock low timeout");
  a_reset_quiet: assert property ($rose(resetn) |-> !sda_oe && !alert_oe && !conv_start)
    else $error("outputs active after reset");
  a_bus_free: assert property (s_stop |=> !sda_oe [*4])
    else $error("data pulled after stop");
endmodule

bind tsr_top tsr_chk #(.CONV_CYC(CONV_CYC), .TOUT_CYC(TOUT_CYC)) tsr_chk_i (
  .clk(clk), .resetn(resetn), .scl(scl), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
  .addr_select_0(addr_select_0), .addr_select_1(addr_select_1),
  .addr_select_2(addr_select_2), .proportional_sensor_code(proportional_sensor_code),
  .conv_start(conv_start), .alert_o(alert_o), .alert_oe(alert_oe));
`default_nettype wire

// ==== verification/tsr_master_model.sv ====
// Purpose: two-wire bus master driving serial clock and data pull-down
// Assumes: data wire resolved outside with a pull-up
// Notes: clock stands high outside frames, 15 ns per bit inside
`timescale 1ns/1ps
`default_nettype none
module tsr_master_model (
  output var  logic scl,
  output var  logic sda_pull,
  input  wire logic sda
);
  logic [8:0] got_val;
  event       got;

  initial
  begin
    scl      = 1'b1;
    sda_pull = 1'b0;
    got_val  = 9'h000;
  end

  // Data set while clock low, sampled while high
  task automatic bit_io(input logic b, output logic r);
    sda_pull = ~b;
    #5.5 scl = 1'b1;
    #1 r = sda;
    #6.5 scl = 1'b0;
    #2;
  endtask

  task automatic start_cond();
    if (scl === 1'b0)
    begin
      sda_pull = 1'b0;
      #5.5 scl = 1'b1;
    end
    #120 sda_pull = 1'b1;
    #120 scl = 1'b0;
    #2;
  endtask

  task automatic stop_cond();
    sda_pull = 1'b1;
    #5.5 scl = 1'b1;
    #120 sda_pull = 1'b0;
    #200;
  endtask

  task automatic send(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], r);
    bit_io(1'b1, r);
    got_val = {~r, b};
    ->got;
  endtask

  task automatic recv(input logic last);
    logic [7:0] v;
    logic       r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      v[i] = r;
    end
    bit_io(last, r);
    got_val = {1'b0, v};
    ->got;
  endtask
endmodule
`default_nettype wire

// ==== verification/test_tsr_top.sv ====
// Purpose: self-checking bench for the serial temperature sensor block
// Assumes: master model drives the serial pins, bench drives core inputs
// Notes: short conversion and timeout counts keep the run brief
`timescale 1ns/1ps
`default_nettype none
module test_tsr_top;
  localparam int          CONV  = 200;
  localparam int          TOUT  = 2000;
  localparam logic [15:0] MAKER = 16'h5A5A; // Arbitrary value
  localparam logic [15:0] PART  = 16'h0101; // Arbitrary value
  typedef struct {
    logic [8:0] e;
    logic [8:0] m;
    string      n;
  } tsr_note_s;
  logic        clk    = 1'b0;
  logic        resetn = 1'b1;
  logic [2:0]  strap  = 3'h5;
  logic [12:0] code   = 13'h0000;
  logic [15:0] hi     = 16'h0000;
  logic [15:0] lo     = 16'h0000;
  logic [15:0] cr     = 16'h0000;
  logic        scl;
  logic        pull;
  logic        sda_oe;
  logic        alert_oe;
  logic        conv_start;
  wire  logic  sda;
  int          errors = 0;
  int          comparisons = 0;
  tsr_note_s   notes[$];

  always #2 clk = ~clk;
  assign sda = ~(pull | sda_oe);

  tsr_top #(.CONV_CYC(CONV), .TOUT_CYC(TOUT), .MAKER_ID(MAKER), .PART_REV(PART)) tsr_top_i (
    .clk(clk), .resetn(resetn), .scl(scl), .sda_i(sda), .sda_o(), .sda_oe(sda_oe),
    .addr_select_0(strap[0]), .addr_select_1(strap[1]), .addr_select_2(strap[2]),
    .proportional_sensor_code(code), .conv_start(conv_start), .alert_o(),
    .alert_oe(alert_oe));
  tsr_master_model tsr_master_model_i (.scl(scl), .sda_pull(pull), .sda(sda));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input string n, input logic [15:0] e, input logic [15:0] s);
    comparisons++;
    if (s !== e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask

  // Oldest note against each byte the master finishes
  always @(tsr_master_model_i.got)
  begin
    tsr_note_s x;
    if (notes.size() == 0)
      check("unexpected byte", 16'h0001, 16'h0000);
    else
    begin
      x = notes.pop_front();
      check(x.n, {7'h00, x.e & x.m}, {7'h00, tsr_master_model_i.got_val & x.m});
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [2:0] trip(input logic [12:0] t);
    trip[2] = $signed(t) >= $signed(cr[12:0]);
    trip[1] = $signed(t) > $signed(hi[12:0]);
    trip[0] = $signed(t) < $signed(lo[12:0]);
  endfunction

  function automatic logic [15:0] rv(input int p);
    case (p)
      0: rv = tsr_pkg::CAP_RESET;
      5: rv = {trip(13'h0000), 13'h0000};
      6: rv = MAKER;
      7: rv = PART;
      default: rv = 16'h0000;
    endcase
  endfunction

  task automatic tx(input logic [7:0] b, input logic a);
    notes.push_back('{{a, 8'h00}, 9'h100, "ack"});
    tsr_master_model_i.send(b);
  endtask

  task automatic rx(input logic [7:0] e, input logic last);
    notes.push_back('{{1'b0, e}, 9'h0FF, "read byte"});
    tsr_master_model_i.recv(last);
  endtask

  task automatic wr_reg(input logic [7:0] p, input logic [15:0] v);
    tsr_master_model_i.start_cond();
    tx({tsr_pkg::PREAMBLE, strap, 1'b0}, 1'b1);
    tx(p, 1'b1);
    tx(v[15:8], 1'b1);
    tx(v[7:0], 1'b1);
    tsr_master_model_i.stop_cond();
    repeat (8) @(posedge clk);
  endtask

  task automatic rd_now(input logic [15:0] e);
    tsr_master_model_i.start_cond();
    tx({tsr_pkg::PREAMBLE, strap, 1'b1}, 1'b1);
    rx(e[15:8], 1'b0);
    rx(e[7:0], 1'b1);
    tsr_master_model_i.stop_cond();
  endtask

  task automatic rd_reg(input logic [7:0] p, input logic [15:0] e);
    tsr_master_model_i.start_cond();
    tx({tsr_pkg::PREAMBLE, strap, 1'b0}, 1'b1);
    tx(p, 1'b1);
    rd_now(e);
  endtask

  task automatic set_lim(input logic [15:0] h, input logic [15:0] l, input logic [15:0] c);
    wr_reg(tsr_pkg::PTR_HIGH, h);
    wr_reg(tsr_pkg::PTR_LOW, l);
    wr_reg(tsr_pkg::PTR_CRIT, c);
    hi = h & tsr_pkg::LIMIT_MASK;
    lo = l & tsr_pkg::LIMIT_MASK;
    cr = c & tsr_pkg::LIMIT_MASK;
  endtask

  task automatic wait_conv();
    int n;
    n = 0;
    // Skip a tick that captured the previous code
    @(posedge clk);
    #1;
    while (conv_start !== 1'b1 && n < 400)
    begin
      @(posedge clk);
      #1 n++;
    end
    if (n == 400)
    begin
      errors++;
      end_of_test();
    end
    repeat (3) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #400000 errors++;
    end_of_test();
  end

  initial
  begin
    // Reset asserted after time zero so every reset edge is seen
    #1 resetn = 1'b0;
    void'($urandom(32'h43F4));
    strap = 3'($urandom);
    repeat (10) @(posedge clk);
    #1 resetn = 1'b1;
    repeat (3) @(posedge clk);
    check("alert pin", 16'h0000, {15'h0000, alert_oe});
    rd_now(tsr_pkg::CAP_RESET);
    for (int p = 0; p < 9; p++)
      rd_reg(p[7:0], rv(p));
    set_lim(16'($urandom), 16'($urandom), 16'($urandom));
    rd_reg(tsr_pkg::PTR_HIGH, hi);
    rd_reg(tsr_pkg::PTR_LOW, lo);
    rd_reg(tsr_pkg::PTR_CRIT, cr);
    wr_reg(tsr_pkg::PTR_CAP, 16'hFFFF);
    wr_reg(tsr_pkg::PTR_MAKER, 16'h0000);
    rd_reg(tsr_pkg::PTR_CAP, tsr_pkg::CAP_RESET);
    rd_reg(tsr_pkg::PTR_MAKER, MAKER);
    tsr_master_model_i.start_cond();
    tx({tsr_pkg::PREAMBLE, strap, 1'b0}, 1'b1);
    tx(tsr_pkg::PTR_HIGH, 1'b1);
    tx(8'h0F, 1'b1);
    tsr_master_model_i.stop_cond();
    rd_reg(tsr_pkg::PTR_HIGH, hi);
    for (int k = 0; k < 7; k++)
    begin
      tsr_master_model_i.start_cond();
      if (k < 4)
        tx({tsr_pkg::PREAMBLE ^ 4'(1 << k), strap, 1'b1}, 1'b0);
      else
        tx({tsr_pkg::PREAMBLE, strap ^ 3'(1 << (k - 4)), 1'b0}, 1'b0);
      tsr_master_model_i.stop_cond();
    end
    wr_reg(tsr_pkg::PTR_CFG, 16'h0008);
    for (int i = 0; i < 4; i++)
    begin
      set_lim(16'($urandom), 16'($urandom), 16'($urandom));
      @(posedge clk);
      #1 code = 13'($urandom);
      wait_conv();
      rd_reg(tsr_pkg::PTR_TEMP, {trip(code), code});
      check("alert pin", {15'h0000, |trip(code)}, {15'h0000, alert_oe});
    end
    set_lim(16'h0FFC, 16'h1000, 16'h0FFC);
    @(posedge clk);
    #1 code = 13'h0000;
    wait_conv();
    check("alert pin", 16'h0000, {15'h0000, alert_oe});
    wr_reg(tsr_pkg::PTR_HIGH, 16'h1000);
    check("alert pin", 16'h0001, {15'h0000, alert_oe});
    wr_reg(tsr_pkg::PTR_CFG, 16'h000A);
    rd_reg(tsr_pkg::PTR_CFG, 16'h001A);
    check("alert pin", 16'h0000, {15'h0000, alert_oe});
    wr_reg(tsr_pkg::PTR_CFG, 16'h000D);
    check("alert pin", 16'h0001, {15'h0000, alert_oe});
    wr_reg(tsr_pkg::PTR_CFG, 16'h002D);
    check("alert pin", 16'h0000, {15'h0000, alert_oe});
    rd_reg(tsr_pkg::PTR_PART, PART);
    tsr_master_model_i.start_cond();
    tx({tsr_pkg::PREAMBLE, strap, 1'b1}, 1'b1);
    repeat (4) @(posedge clk);
    check("data pull", {15'h0000, ~PART[15]}, {15'h0000, sda_oe});
    repeat (TOUT + 50) @(posedge clk);
    check("data pull", 16'h0000, {15'h0000, sda_oe});
    tsr_master_model_i.stop_cond();
    rd_now(tsr_pkg::CAP_RESET);
    end_of_test();
  end
endmodule
`default_nettype wire
